// ==== core/sof_pkg.sv ====
// Purpose: constants, register map and carrier types for the serial output framer
// Assumes: one-sided readout; word sizes 8, 10 or 12 bits
// Notes:   register offsets are byte-free indexes on the serial config port
package sof_pkg;
   localparam logic [6:0]  REG_ROW_COUNT   = 7'h01;
   localparam logic [6:0]  REG_CHAN_MODE   = 7'h51;
   localparam logic [6:0]  REG_TRAIN       = 7'h59;
   localparam logic [6:0]  REG_CHAN_OFF_LO = 7'h5C;
   localparam logic [6:0]  REG_CHAN_OFF_HI = 7'h5D;
   localparam logic [6:0]  REG_WORD_SIZE   = 7'h76;
   localparam logic [6:0]  REG_STATUS      = 7'h7F;

   localparam logic [15:0] ROW_COUNT_RST   = 16'h0C00;
   localparam logic [2:0]  CHAN_MODE_RST   = 3'h0;
   localparam logic [11:0] TRAIN_RST       = 12'h055;
   localparam logic [1:0]  WORD_SIZE_RST   = 2'h1;
   localparam logic [31:0] CHAN_OFF_RST    = 32'h0000_0000;

   localparam logic [7:0]  BURST_WORDS     = 8'h80;
   localparam logic [1:0]  ROWGAP_LAST     = 2'h1;
   localparam logic [4:0]  SPI_ADDR_BITS   = 5'h08;
   localparam logic [4:0]  SPI_FRAME_BITS  = 5'h18;
   localparam int          NUM_CH          = 64;
   localparam int          SIDE_CH         = 32;

   typedef struct packed {
      logic [15:0] rows;
      logic [2:0]  chan_mode;
      logic [1:0]  word_size;
      logic [11:0] train;
      logic [31:0] chan_off;
   } sof_cfg_t;

   localparam sof_cfg_t CFG_RST = '{rows: ROW_COUNT_RST, chan_mode: CHAN_MODE_RST,
                                    word_size: WORD_SIZE_RST, train: TRAIN_RST,
                                    chan_off: CHAN_OFF_RST};

   typedef logic [SIDE_CH-1:0][11:0] sof_pix_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_PRE    = 3'b001,
      ST_BURST  = 3'b010,
      ST_GAP    = 3'b011,
      ST_ROWGAP = 3'b100
   } sof_state_t;

   function automatic logic [3:0] sof_word_bits(input logic [1:0] ws);
      case (ws)
         2'h0:    sof_word_bits = 4'h8;
         2'h2:    sof_word_bits = 4'hC;
         default: sof_word_bits = 4'hA;
      endcase
   endfunction
endpackage

// ==== core/sof_top.sv ====
// Purpose: framing of the serial pixel outputs and the control channel
// Assumes: LINK_CLK_I is the free running output bit clock; one bit per rising edge
// Notes:   config from the serial port reaches the link side by toggle handshake
module sof_top (
   input  wire logic                  CORE_CLK_I,
   input  wire logic                  RESET_I,
   input  wire logic                  LINK_CLK_I,
   input  wire logic                  SPI_CLK_I,
   input  wire logic                  SPI_EN_I,
   input  wire logic                  SPI_DIN_I,
   output      logic                  SPI_DOUT_O,
   input  wire logic                  FRAME_REQ_I,
   input  wire logic                  SAMPLING_I,
   input  wire logic                  INTEG_ONE_I,
   input  wire logic                  INTEG_TWO_I,
   input  wire sof_pkg::sof_pix_t     PIX_I,
   output      logic [15:0]           PIX_ROW_O,
   output      logic [4:0]            PIX_BURST_O,
   output      logic [6:0]            PIX_COL_O,
   output      logic [63:0]           DATA_O,
   output      logic                  CTRL_O
);

   typedef struct packed {
      logic [2:0]       clk_s;
      logic [2:0]       en_s;
      logic [2:0]       din_s;
      logic [2:0]       ack_s;
      logic [2:0]       busy_s;
      logic             clk_f;
      logic             en_f;
      logic             din_f;
      logic             ack_f;
      logic             busy_f;
      logic [4:0]       cnt;
      logic [23:0]      sr;
      logic [6:0]       addr;
      logic             dout;
      logic             req_tgl;
      sof_pkg::sof_cfg_t cfg;
      sof_pkg::sof_cfg_t xfer;
   } sof_core_t;

   typedef struct packed {
      logic [2:0]       req_s;
      logic [2:0]       frm_s;
      logic [2:0][2:0]  fl_s;
      logic             req_f;
      logic             frm_f;
      logic             frm_prev;
      logic             frm_pend;
      logic [2:0]       fl_f;
      logic             ack_tgl;
      logic             active;
      sof_pkg::sof_state_t st;
      logic [3:0]       bit_cnt;
      logic [7:0]       pix_cnt;
      logic [4:0]       burst_cnt;
      logic [15:0]      row_cnt;
      logic [15:0]      row_emit;
      logic [1:0]       gap_cnt;
      sof_pkg::sof_cfg_t cfg;
      sof_pkg::sof_pix_t hold;
      logic [63:0]      data;
      logic             ctrl;
   } sof_link_t;

   sof_core_t core;
   sof_core_t next_core;
   sof_link_t lnk;
   sof_link_t next_lnk;
   logic      lnk_end;
   logic [11:0] ctrl_word;

   function automatic logic [15:0] rd_reg(input logic [6:0] a,
                                          input sof_pkg::sof_cfg_t c,
                                          input logic busy,
                                          input logic pend);
      case (a)
         sof_pkg::REG_ROW_COUNT:   rd_reg = c.rows;
         sof_pkg::REG_CHAN_MODE:   rd_reg = {13'h0000, c.chan_mode};
         sof_pkg::REG_TRAIN:       rd_reg = {4'h0, c.train};
         sof_pkg::REG_CHAN_OFF_LO: rd_reg = c.chan_off[15:0];
         sof_pkg::REG_CHAN_OFF_HI: rd_reg = c.chan_off[31:16];
         sof_pkg::REG_WORD_SIZE:   rd_reg = {14'h0000, c.word_size};
         sof_pkg::REG_STATUS:      rd_reg = {14'h0000, pend, busy};
         default:                  rd_reg = 16'h0000;
      endcase
   endfunction

   // serial configuration port, slow against CORE_CLK_I
   always_comb begin
      logic        rise;
      logic [4:0]  cnt;
      logic [23:0] sr;
      logic [6:0]  a;
      logic [15:0] rd;
      rise = 1'b0;
      cnt = core.cnt;
      sr = core.sr;
      a = core.addr;
      rd = 16'h0000;
      next_core = core;
      next_core.clk_s = {core.clk_s[1:0], SPI_CLK_I};
      next_core.en_s = {core.en_s[1:0], SPI_EN_I};
      next_core.din_s = {core.din_s[1:0], SPI_DIN_I};
      next_core.ack_s = {core.ack_s[1:0], lnk.ack_tgl};
      next_core.busy_s = {core.busy_s[1:0], lnk.active};
      if (core.clk_s[1] == core.clk_s[2]) next_core.clk_f = core.clk_s[2];
      if (core.en_s[1] == core.en_s[2]) next_core.en_f = core.en_s[2];
      if (core.din_s[1] == core.din_s[2]) next_core.din_f = core.din_s[2];
      if (core.ack_s[1] == core.ack_s[2]) next_core.ack_f = core.ack_s[2];
      if (core.busy_s[1] == core.busy_s[2]) next_core.busy_f = core.busy_s[2];
      rise = next_core.clk_f & ~core.clk_f;
      if (!core.en_f) begin
         next_core.cnt = 5'h00;
      end else if (rise && core.cnt != sof_pkg::SPI_FRAME_BITS) begin
         sr = {core.sr[22:0], core.din_f};
         cnt = core.cnt + 5'h01;
         if (cnt == sof_pkg::SPI_ADDR_BITS) a = sr[6:0];
         rd = rd_reg(a, core.cfg, core.busy_f, core.req_tgl ^ core.ack_f);
         if (cnt >= sof_pkg::SPI_ADDR_BITS && cnt < sof_pkg::SPI_FRAME_BITS) begin
            next_core.dout = rd[4'(5'h17 - cnt)];
         end
         // top bit of a full frame is the write flag
         if (cnt == sof_pkg::SPI_FRAME_BITS && sr[23]) begin
            case (a)
               sof_pkg::REG_ROW_COUNT:   next_core.cfg.rows = sr[15:0];
               sof_pkg::REG_CHAN_MODE:   next_core.cfg.chan_mode = sr[2:0];
               sof_pkg::REG_TRAIN:       next_core.cfg.train = sr[11:0];
               sof_pkg::REG_CHAN_OFF_LO: next_core.cfg.chan_off[15:0] = sr[15:0];
               sof_pkg::REG_CHAN_OFF_HI: next_core.cfg.chan_off[31:16] = sr[15:0];
               sof_pkg::REG_WORD_SIZE:   next_core.cfg.word_size = sr[1:0];
               default:                  next_core.cfg = core.cfg;
            endcase
         end
         next_core.sr = sr;
         next_core.cnt = cnt;
         next_core.addr = a;
      end
      // xfer stays frozen until the link side acknowledges it
      if (core.cfg != core.xfer && core.req_tgl == core.ack_f) begin
         next_core.xfer = core.cfg;
         next_core.req_tgl = ~core.req_tgl;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         core <= '0;
         core.cfg <= sof_pkg::CFG_RST;
         core.xfer <= sof_pkg::CFG_RST;
      end else begin
         core <= next_core;
      end
   end

   assign SPI_DOUT_O = core.dout;

   assign lnk_end = lnk.bit_cnt == sof_pkg::sof_word_bits(lnk.cfg.word_size) - 4'h1;

   // control word: constants and status flags
   always_comb begin
      ctrl_word = 12'h080;
      ctrl_word[0] = lnk.st == sof_pkg::ST_BURST;
      ctrl_word[1] = lnk.st == sof_pkg::ST_BURST || lnk.st == sof_pkg::ST_GAP;
      ctrl_word[2] = lnk.st != sof_pkg::ST_IDLE;
      ctrl_word[5:3] = lnk.fl_f;
   end

   // link side framing on the output bit clock
   always_comb begin
      logic [4:0]  msk;
      logic [11:0] train_pri;
      logic [11:0] train_sec;
      logic [11:0] w;
      logic        act;
      msk = 5'h00;
      train_pri = 12'h000;
      train_sec = 12'h000;
      w = 12'h000;
      act = 1'b0;
      next_lnk = lnk;
      next_lnk.req_s = {lnk.req_s[1:0], core.req_tgl};
      next_lnk.frm_s = {lnk.frm_s[1:0], FRAME_REQ_I};
      next_lnk.fl_s = {lnk.fl_s[1:0], {INTEG_TWO_I, INTEG_ONE_I, SAMPLING_I}};
      if (lnk.req_s[1] == lnk.req_s[2]) next_lnk.req_f = lnk.req_s[2];
      if (lnk.frm_s[1] == lnk.frm_s[2]) next_lnk.frm_f = lnk.frm_s[2];
      for (int i = 0; i < 3; i++) begin
         if (lnk.fl_s[1][i] == lnk.fl_s[2][i]) next_lnk.fl_f[i] = lnk.fl_s[2][i];
      end
      next_lnk.frm_prev = lnk.frm_f;
      next_lnk.bit_cnt = lnk_end ? 4'h0 : lnk.bit_cnt + 4'h1;
      msk = 5'(~(5'h1F << lnk.cfg.chan_mode));
      if (lnk_end) begin
         unique case (lnk.st)
            sof_pkg::ST_IDLE: begin
               if (lnk.req_f != lnk.ack_tgl) begin
                  // config only changes between frames
                  next_lnk.cfg = core.xfer;
                  next_lnk.ack_tgl = ~lnk.ack_tgl;
               end else if (lnk.frm_pend && lnk.cfg.rows != 16'h0000) begin
                  next_lnk.frm_pend = 1'b0;
                  next_lnk.st = sof_pkg::ST_PRE;
                  next_lnk.row_cnt = 16'h0000;
                  next_lnk.burst_cnt = 5'h00;
                  next_lnk.pix_cnt = 8'h00;
               end
            end
            sof_pkg::ST_PRE, sof_pkg::ST_GAP: begin
               next_lnk.hold = PIX_I;
               next_lnk.pix_cnt = 8'h01;
               next_lnk.st = sof_pkg::ST_BURST;
            end
            sof_pkg::ST_BURST: begin
               if (lnk.pix_cnt == sof_pkg::BURST_WORDS) begin
                  next_lnk.pix_cnt = 8'h00;
                  if (lnk.burst_cnt == msk) begin
                     next_lnk.burst_cnt = 5'h00;
                     next_lnk.row_cnt = lnk.row_cnt + 16'h0001;
                     next_lnk.gap_cnt = 2'h0;
                     if (lnk.row_cnt + 16'h0001 == lnk.cfg.rows) begin
                        next_lnk.st = sof_pkg::ST_IDLE;
                     end else begin
                        next_lnk.st = sof_pkg::ST_ROWGAP;
                     end
                  end else begin
                     next_lnk.burst_cnt = lnk.burst_cnt + 5'h01;
                     next_lnk.st = sof_pkg::ST_GAP;
                  end
               end else begin
                  next_lnk.hold = PIX_I;
                  next_lnk.pix_cnt = lnk.pix_cnt + 8'h01;
               end
            end
            sof_pkg::ST_ROWGAP: begin
               next_lnk.gap_cnt = lnk.gap_cnt + 2'h1;
               if (lnk.gap_cnt == sof_pkg::ROWGAP_LAST) next_lnk.st = sof_pkg::ST_PRE;
            end
            default: next_lnk.st = sof_pkg::ST_IDLE;
         endcase
      end
      // a new request landing with the clear above still counts
      if (lnk.frm_f && !lnk.frm_prev) next_lnk.frm_pend = 1'b1;
      next_lnk.row_emit = next_lnk.row_cnt ^ {15'h0000, next_lnk.row_cnt[1]};
      next_lnk.active = next_lnk.st != sof_pkg::ST_IDLE;
      train_pri = lnk.cfg.train;
      train_sec = {4'h0, ~train_pri[7:0]};
      for (int c = 0; c < sof_pkg::NUM_CH; c++) begin
         // only every stride-th lower channel carries pixels
         act = c < sof_pkg::SIDE_CH && (5'(c) & msk) == 5'h00;
         if (lnk.st == sof_pkg::ST_BURST && act) begin
            w = lnk.hold[5'(c) >> lnk.cfg.chan_mode];
         end else if (lnk.st == sof_pkg::ST_PRE) begin
            w = train_sec;
         end else begin
            w = train_pri;
         end
         next_lnk.data[c] = ~lnk.cfg.chan_off[c / 2] & w[lnk.bit_cnt];
      end
      next_lnk.ctrl = ctrl_word[lnk.bit_cnt];
   end

   always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         lnk <= '0;
         lnk.cfg <= sof_pkg::CFG_RST;
      end else begin
         lnk <= next_lnk;
      end
   end

   assign DATA_O = lnk.data;
   assign CTRL_O = lnk.ctrl;
   assign PIX_ROW_O = lnk.row_emit;
   assign PIX_BURST_O = lnk.burst_cnt;
   assign PIX_COL_O = lnk.pix_cnt[6:0];

   a_pre_one_word: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      (lnk.st == sof_pkg::ST_PRE && lnk_end) |=> lnk.st == sof_pkg::ST_BURST)
      else $error("secondary word lasted more than one word");

   a_gap_one_word: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      (lnk.st == sof_pkg::ST_GAP && lnk_end) |=> lnk.st == sof_pkg::ST_BURST)
      else $error("burst gap not one word");

   a_burst_length: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      (lnk.st == sof_pkg::ST_BURST && lnk_end && lnk.pix_cnt != sof_pkg::BURST_WORDS)
      |=> lnk.st == sof_pkg::ST_BURST)
      else $error("burst ended before 128 words");

   a_ctrl_bit_seven: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      lnk.bit_cnt == 4'h7 |=> CTRL_O && !$past(CTRL_O))
      else $error("control bit 7 not one or bit 6 not zero");

   a_row_valid_rise: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      $rose(ctrl_word[1]) |-> $past(lnk.st) == sof_pkg::ST_PRE)
      else $error("row valid rose without secondary word");

   // watched on the serial pin, so the serialiser order is covered too
   a_pixel_valid_inside: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      (lnk.bit_cnt == 4'h1 && CTRL_O) |=> CTRL_O ##1 CTRL_O)
      else $error("pixel valid outside row or frame");

   a_row_swap: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      ($changed(lnk.row_cnt) && lnk.row_cnt[1:0] == 2'h2) |-> lnk.row_emit[1:0] == 2'h3)
      else $error("third row of four not swapped");

   a_frame_rows: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      (lnk.st == sof_pkg::ST_BURST ##1 lnk.st == sof_pkg::ST_IDLE)
      |-> lnk.row_cnt == lnk.cfg.rows)
      else $error("frame row count mismatch");

   a_gap_train: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      (lnk.st == sof_pkg::ST_GAP && lnk.bit_cnt == 4'h0)
      |=> DATA_O[0] == (~lnk.cfg.chan_off[0] & lnk.cfg.train[0]))
      else $error("gap word not primary training");

   a_secondary_lsb: assert property (
      @(posedge LINK_CLK_I) disable iff (RESET_I)
      (lnk.st == sof_pkg::ST_PRE && lnk.bit_cnt == 4'h0)
      |=> DATA_O[1] == (~lnk.cfg.chan_off[0] & ~lnk.cfg.train[0]))
      else $error("secondary word bit 0 wrong");

endmodule

// ==== verification/sof_rx_model.sv ====
// Purpose: receiver model: control channel word lock, deserialising of every lane
// Assumes: one bit per link rising edge, least significant bit first
// Notes:   relocks whenever the word width changes
module sof_rx_model (
   input  wire logic              link_clk_i,
   input  wire logic              rst_i,
   input  wire logic [3:0]        width_i,
   input  wire logic              ctrl_i,
   input  wire logic [63:0]       data_i,
   output      logic              stb_o,
   output      logic [11:0]       ctrl_word_o,
   output      logic [63:0][11:0] data_word_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [11:0]       c_sh;
   logic [63:0][11:0] d_sh;
   logic [3:0]        ph;
   logic [3:0]        w_last;
   logic              locked;
   // sampled mid-bit, away from the launching edge
   always @(negedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         c_sh = '0;
         d_sh = '0;
         ph = '0;
         w_last = '0;
         locked = 1'b0;
         stb_o = 1'b0;
      end else begin
         c_sh = {ctrl_i, c_sh[11:1]};
         // no lane skew here: training words must already sit on the control boundary
         for (int c = 0; c < 64; c++) d_sh[c] = {data_i[c], d_sh[c][11:1]};
         if (width_i != w_last) locked = 1'b0;
         w_last = width_i;
         ph = (ph == width_i - 4'h1) ? 4'h0 : ph + 4'h1;
         // idle control word with status flags low has a lone one: the only safe boundary marker
         if (!locked && (c_sh >> (4'hC - width_i)) == 12'h080) begin
            locked = 1'b1;
            ph = 4'h0;
         end
         stb_o = locked && ph == 4'h0;
         if (stb_o) begin
            ctrl_word_o = c_sh >> (4'hC - width_i);
            for (int c = 0; c < 64; c++) data_word_o[c] = d_sh[c] >> (4'hC - width_i);
         end
      end
   end
endmodule

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the serial output framer
// Assumes: frames run with 12 bit words; core 40 ns, link 125 ns
// Notes:   pixel words encode row, lane, burst and column so misplacement shows
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic              core_clk  = 1'b0;
   logic              link_clk  = 1'b0;
   logic              rst       = 1'b1;
   logic              spi_clk   = 1'b0;
   logic              spi_en    = 1'b0;
   logic              spi_din   = 1'b0;
   logic              frame_req = 1'b0;
   logic [2:0]        st_in     = 3'h0;
   sof_pkg::sof_pix_t pix       = '0;
   logic              spi_dout;
   logic [15:0]       pix_row;
   logic [4:0]        pix_burst;
   logic [6:0]        pix_col;
   logic [63:0]       data;
   logic              ctrl;
   logic              stb;
   logic [11:0]       cw;
   logic [63:0][11:0] dw;
   logic [11:0]       pcw;
   logic [11:0]       ppcw;
   logic [63:0][11:0] pdw;
   logic [3:0]        rx_w      = 4'hA;
   logic              live      = 1'b0;
   logic              pok       = 1'b0;
   logic [11:0]       tp        = sof_pkg::TRAIN_RST;
   logic [2:0]        st_exp    = 3'h0;
   logic [2:0]        mode      = 3'h0;
   logic [31:0]       off       = '0;
   logic [15:0]       rd;
   logic [15:0]       q[$];
   int                mismatches = 0;
   int                comparisons = 0;
   int                seed = 25584;
   int                cyc = 0;

   initial forever #20 core_clk = ~core_clk;
   initial begin
      #7;
      forever #62.5 link_clk = ~link_clk;
   end

   sof_top dut_u (.CORE_CLK_I(core_clk), .RESET_I(rst), .LINK_CLK_I(link_clk),
      .SPI_CLK_I(spi_clk), .SPI_EN_I(spi_en), .SPI_DIN_I(spi_din), .SPI_DOUT_O(spi_dout),
      .FRAME_REQ_I(frame_req), .SAMPLING_I(st_in[0]), .INTEG_ONE_I(st_in[1]),
      .INTEG_TWO_I(st_in[2]), .PIX_I(pix), .PIX_ROW_O(pix_row), .PIX_BURST_O(pix_burst),
      .PIX_COL_O(pix_col), .DATA_O(data), .CTRL_O(ctrl));
   sof_rx_model rx_u (.link_clk_i(link_clk), .rst_i(rst), .width_i(rx_w), .ctrl_i(ctrl),
      .data_i(data), .stb_o(stb), .ctrl_word_o(cw), .data_word_o(dw));

   // pixel source answers the fetch index well before the next word end
   always @(negedge link_clk)
      for (int a = 0; a < 32; a++) pix[a] <= {pix_row[2:0], a[4:0] ^ {pix_burst[0], 4'h0}, pix_col[3:0]};

   task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
      comparisons++;
      if (got !== want) begin
         mismatches++;
         $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, want);
      end
   endtask

   function automatic logic [11:0] expw(input int c, input logic [15:0] e);
      logic [11:0] v;
      if (off[c/2]) return 12'h000;
      if (pcw[0] && c < 32 && (c % (1 << mode)) == 0)
         v = {e[9:7], 5'(c >> mode) ^ {e[15], 4'h0}, e[3:0]};
      else if (cw[1] && !pcw[1]) v = {4'h0, ~tp[7:0]};
      else v = tp;
      return v & 12'((1 << rx_w) - 1);
   endfunction

   // judges each word once the next one shows whether row valid rises
   always @(posedge link_clk) begin
      logic [15:0] e;
      e = 16'h0;
      if (!live) begin
         pok = 1'b0;
      end else if (stb) begin
         chk(cw & 12'hFC0, 12'h080, "fixed bits");
         chk(16'(cw[5:3]), 16'(st_exp), "status bits");
         if (cw[0] || cw[1]) chk(16'(cw[2:1]), 16'h3, "row frame flags");
         if (pok && pcw[0]) begin
            if (q.size() == 0) chk(16'h1, 16'h0, "extra pixel word");
            else e = q.pop_front();
         end
         if (pok) for (int c = 0; c < 64; c++) chk(pdw[c], expw(c, e), "lane word");
         if (pok && cw[0] && pcw[1] && !pcw[0]) chk(16'(ppcw[0]), 16'h1, "gap length");
         ppcw = pcw;
         pcw = cw;
         pdw = dw;
         pok = 1'b1;
      end
   end

   task automatic lw(input int n);
      repeat (n) @(posedge link_clk);
      @(negedge core_clk);
   endtask

   task automatic spi(input logic wr, input logic [6:0] adr, input logic [15:0] wd);
      logic [23:0] f;
      f = {wr, adr, wd};
      spi_en = 1'b1;
      for (int i = 0; i < 24; i++) begin
         spi_din = f[23 - i];
         repeat (8) @(negedge core_clk);
         if (i >= 8) rd[23 - i] = spi_dout;
         spi_clk = 1'b1;
         repeat (8) @(negedge core_clk);
         spi_clk = 1'b0;
      end
      spi_en = 1'b0;
      repeat (8) @(negedge core_clk);
   endtask

   task automatic rdchk(input logic [6:0] adr, input logic [15:0] want);
      spi(1'b0, adr, 16'h0000);
      chk(rd, want, "register read");
   endtask

   task automatic frame(input logic [2:0] m, input logic [15:0] rows);
      live = 1'b0;
      spi(1'b1, sof_pkg::REG_CHAN_MODE, 16'(m));
      spi(1'b1, sof_pkg::REG_ROW_COUNT, rows);
      mode = m;
      for (int r = 0; r < rows; r++)
         for (int b = 0; b < (1 << m); b++)
            for (int p = 0; p < 128; p++) q.push_back({b[0], 8'(r ^ ((r >> 1) & 1)), p[6:0]});
      lw(40);
      live = 1'b1;
      lw(20);
      frame_req = 1'b1;
      lw(8);
      frame_req = 1'b0;
      rdchk(sof_pkg::REG_STATUS, 16'h0001);
      for (int t = 0; t < 20000 && q.size() != 0; t++) @(posedge link_clk);
      lw(60);
      chk(16'(q.size()), 16'h0, "frame length");
      chk(16'(cw[2:0]), 16'h0, "frame closed");
      $display("test frame mode %0d done", m);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         mismatches++;
         $display("CHECK FAILED %0t run did not finish", $time);
         wrap_up;
      end
   end

   initial begin
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      repeat (10) @(negedge core_clk);
      rdchk(sof_pkg::REG_ROW_COUNT, 16'h0C00);
      rdchk(sof_pkg::REG_TRAIN, 16'(sof_pkg::TRAIN_RST));
      rdchk(7'h10, 16'h0000);
      rdchk(sof_pkg::REG_STATUS, 16'h0000);
      $display("test register reads done");
      live = 1'b1;
      lw(80);
      $display("test idle words done");
      for (int i = 0; i < 2; i++) begin
         live = 1'b0;
         spi(1'b1, sof_pkg::REG_WORD_SIZE, (i == 0) ? 16'h0000 : 16'h0002);
         lw(30);
         rx_w = (i == 0) ? 4'h8 : 4'hC;
         lw(60);
         live = 1'b1;
         lw(80);
         $display("test width %0d done", rx_w);
      end
      live = 1'b0;
      st_in = 3'($random(seed));
      lw(40);
      st_exp = st_in;
      live = 1'b1;
      lw(60);
      $display("test status bits done");
      live = 1'b0;
      tp = 12'($random(seed));
      spi(1'b1, sof_pkg::REG_TRAIN, 16'(tp));
      rdchk(sof_pkg::REG_TRAIN, 16'(tp));
      spi(1'b1, sof_pkg::REG_CHAN_OFF_HI, 16'hFFFF);
      off = 32'hFFFF_0000;
      frame(3'h0, 16'(4 + ($random(seed) & 1)));
      frame(3'h1, 16'h0002);
      wrap_up;
   end
endmodule
